// >>> rtl/task_file_pkg.sv
// Operation
// - option 2, register line low, A9..A4 1FH, A3 low: A2..A0 pick task file.
// - option 2, A9..A4 3FH, A2..A0 110/111 pick alt status/control or drive address.
// - option 3 decodes alike with 17H for task file and 37H for alternates.
// - IDE mode uses chip select one for task file, two for alternates.
// - reads and writes at a shared address reach different registers.
// - sixteen-bit data port moves sector data, word and byte accesses; the code moves a whole word per access, none if the buffer is full or empty.
// - data port upper byte lane shares the error/feature location; the code decodes is_data_hi there but never uses it.
// - error register is read only, valid only while busy is clear.
// - error bit7 bad block, bit0 general error, bits 5,3,1 read zero.
// - error bit6 set on uncorrectable read data error.
// - error bit4 set when requested sector identity is missing.
// - error bit2 set when a command is aborted.
// - feature byte is write only; reads there return the error register.
// - sector count holds sectors to move; zero means 256.
// - failed multi-sector transfer leaves outstanding count in sector count.
// - sector count resets to 01H.
// - sector number holds starting sector of next transfer.
// - cylinder low and high hold halves of the starting cylinder.
// - drive/head bits 7 and 5 are one, bit6 mode, bit4 unit, 3..0 head.
// - option selector chooses which address mapping is active.
// - mode flag one forms a 28-bit block address, else cylinder/head/sector.
// - status bit7 flags internal operation; other status bits then invalid.
package task_file_pkg;
  localparam logic [1:0] OPT_PRIMARY      = 2'h2;
  localparam logic [1:0] OPT_SECONDARY    = 2'h3;
  localparam logic [5:0] PRI_TASK_BASE    = 6'h1F;
  localparam logic [5:0] PRI_ALT_BASE     = 6'h3F;
  localparam logic [5:0] SEC_TASK_BASE    = 6'h17;
  localparam logic [5:0] SEC_ALT_BASE     = 6'h37;
  localparam logic [2:0] REG_DATA         = 3'h0;
  localparam logic [2:0] REG_ERROR        = 3'h1;
  localparam logic [2:0] REG_COUNT        = 3'h2;
  localparam logic [2:0] REG_SECTOR       = 3'h3;
  localparam logic [2:0] REG_CYL_LOW      = 3'h4;
  localparam logic [2:0] REG_CYL_HIGH     = 3'h5;
  localparam logic [2:0] REG_UNIT_HEAD    = 3'h6;
  localparam logic [2:0] REG_STATUS       = 3'h7;
  localparam logic [2:0] ALT_STATUS       = 3'h6;
  localparam logic [2:0] ALT_DRIVE_ADDR   = 3'h7;
  localparam logic [7:0] COUNT_RESET      = 8'h01;
  localparam logic [7:0] UNIT_HEAD_FIXED  = 8'hA0;
  localparam logic [7:0] UNIT_HEAD_WMASK  = 8'h5F;
  localparam logic [7:0] ERROR_MASK       = 8'hD5;
  localparam int         BIT_BAD_BLOCK    = 7;
  localparam int         BIT_UNCORR       = 6;
  localparam int         BIT_ID_MISSING   = 4;
  localparam int         BIT_ABORTED      = 2;
  localparam int         BIT_GENERAL      = 0;
  localparam int         BIT_MODE         = 6;
  localparam int         BIT_UNIT         = 4;
  localparam int         STATUS_BUSY_BIT  = 7;
  localparam logic [8:0] COUNT_ZERO_MEANS = 9'h100;
endpackage

// >>> rtl/data_fifo.sv
`timescale 1ns/1ps
module data_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clock_i,
  input  wire logic             reset_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              push = in_valid_i && in_ready_o;
  wire              pop  = out_valid_o && out_ready_i;
  // full at DEPTH words; the filler must hold its word until ready returns
  assign in_ready_o  = (cnt_q < (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];
  always_ff @(posedge clock_i) begin
    if (push) mem_q[wr_q] <= in_data_i;
  end
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      if (pop) rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // data_fifo

// >>> rtl/ata_task_file_decode.sv
`timescale 1ns/1ps
module ata_task_file_decode #(
  parameter int DATA_DEPTH = 8
) (
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  // configuration
  input  wire logic        ide_mode_i,
  input  wire logic [1:0]  config_option_i,
  // host pins, asynchronous
  input  wire logic        reg_select_n_i,
  input  wire logic        chip_sel1_n_i,
  input  wire logic        chip_sel2_n_i,
  input  wire logic [10:0] addr_i,
  input  wire logic        io_read_n_i,
  input  wire logic        io_write_n_i,
  input  wire logic [15:0] host_data_i,
  output logic      [15:0] host_data_o,
  output logic             host_data_lo_oe_o,
  output logic             host_data_hi_oe_o,
  // back end: status and error events
  input  wire logic [7:0]  status_i,
  input  wire logic        set_bad_block_i,
  input  wire logic        set_uncorrectable_i,
  input  wire logic        set_id_missing_i,
  input  wire logic        set_aborted_i,
  input  wire logic        set_general_i,
  input  wire logic        clear_errors_i,
  input  wire logic        count_load_i,
  input  wire logic [7:0]  count_remaining_i,
  // back end: command and parameters
  output logic             command_valid_o,
  output logic      [7:0]  command_code_o,
  output logic             control_valid_o,
  output logic      [7:0]  control_byte_o,
  output logic      [7:0]  feature_byte_o,
  output logic      [8:0]  sectors_to_move_o,
  output logic             block_mode_o,
  output logic             unit_select_bit_o,
  output logic      [27:0] block_address_o,
  output logic      [3:0]  head_number_o,
  output logic      [15:0] cylinder_o,
  output logic      [7:0]  start_sector_o,
  // back end: sector data, host writes
  output logic             wr_data_valid_o,
  input  wire logic        wr_data_ready_i,
  output logic      [15:0] wr_data_o,
  // back end: sector data, host reads
  input  wire logic        rd_data_valid_i,
  output logic             rd_data_ready_o,
  input  wire logic [15:0] rd_data_i
);
  localparam int NSYNC = 3;
  // three-stage capture of every host pin
  localparam int PW = 1 + 2 + 11 + 2 + 16;
  logic [PW-1:0] s1_q;
  logic [PW-1:0] s2_q;
  logic [PW-1:0] s3_q;
  logic [PW-1:0] st_q;
  wire  [PW-1:0] pins = {reg_select_n_i, chip_sel1_n_i, chip_sel2_n_i, addr_i,
                         io_read_n_i, io_write_n_i, host_data_i};
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      st_q <= '1;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) st_q <= s3_q;
    end
  end
  wire        regsel_n = st_q[31];
  wire        cs1_n    = st_q[30];
  wire        cs2_n    = st_q[29];
  wire [10:0] a        = st_q[28:18];
  wire        rd_n     = st_q[17];
  wire        wr_n     = st_q[16];
  wire [15:0] wdat     = st_q[15:0];

  // mapping decode
  wire [5:0] a_hi = a[9:4];
  wire       pri  = (config_option_i == task_file_pkg::OPT_PRIMARY);
  wire       sec  = (config_option_i == task_file_pkg::OPT_SECONDARY);
  wire       io_cyc = !ide_mode_i && !regsel_n && !a[3];
  wire       task_sel = ide_mode_i ? (!cs1_n && cs2_n)
                      : io_cyc && ((pri && a_hi == task_file_pkg::PRI_TASK_BASE)
                                || (sec && a_hi == task_file_pkg::SEC_TASK_BASE));
  wire       alt_hit = ide_mode_i ? (!cs2_n && cs1_n)
                      : io_cyc && ((pri && a_hi == task_file_pkg::PRI_ALT_BASE)
                                || (sec && a_hi == task_file_pkg::SEC_ALT_BASE));
  wire       alt_sel = alt_hit && (a[2:1] == 2'h3);
  wire [2:0] idx     = a[2:0];
  wire       sel     = task_sel || alt_sel;
  wire       rd_act  = sel && !rd_n && wr_n;
  wire       wr_act  = sel && !wr_n && rd_n;
  logic      rd_prev_q;
  logic      wr_prev_q;
  wire       rd_start = rd_act && !rd_prev_q;
  wire       wr_start = wr_act && !wr_prev_q;
  wire       is_data  = task_sel && idx == task_file_pkg::REG_DATA;
  // word access: A0 low on data port gives both lanes
  wire       is_data_hi = task_sel && idx == task_file_pkg::REG_ERROR;

  function automatic logic hit(input logic t, input logic [2:0] i, input logic [2:0] r);
    hit = t && (i == r);
  endfunction

  // registers
  logic [7:0] error_q;
  logic [7:0] feature_q;
  logic [7:0] count_q;
  logic [7:0] sector_q;
  logic [7:0] cyl_lo_q;
  logic [7:0] cyl_hi_q;
  logic [7:0] unit_head_q;
  logic [7:0] command_q;
  logic [7:0] control_q;
  logic       cmd_pulse_q;
  logic       ctl_pulse_q;
  logic [7:0] err_set;
  always_comb begin
    err_set = '0;
    err_set[task_file_pkg::BIT_BAD_BLOCK]  = set_bad_block_i;
    err_set[task_file_pkg::BIT_UNCORR]     = set_uncorrectable_i;
    err_set[task_file_pkg::BIT_ID_MISSING] = set_id_missing_i;
    err_set[task_file_pkg::BIT_ABORTED]    = set_aborted_i;
    err_set[task_file_pkg::BIT_GENERAL]    = set_general_i;
  end
  // host writes only error through events; set beats clear
  wire [7:0] error_d = ((clear_errors_i ? 8'h00 : error_q) | err_set)
                       & task_file_pkg::ERROR_MASK;
  wire wr_reg = wr_start && !is_data;
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      rd_prev_q   <= 1'b0;
      wr_prev_q   <= 1'b0;
      error_q     <= 8'h00;
      feature_q   <= 8'h00;
      count_q     <= task_file_pkg::COUNT_RESET;
      sector_q    <= 8'h00;
      cyl_lo_q    <= 8'h00;
      cyl_hi_q    <= 8'h00;
      unit_head_q <= task_file_pkg::UNIT_HEAD_FIXED;
      command_q   <= 8'h00;
      control_q   <= 8'h00;
      cmd_pulse_q <= 1'b0;
      ctl_pulse_q <= 1'b0;
    end else begin
      rd_prev_q   <= rd_act;
      wr_prev_q   <= wr_act;
      error_q     <= error_d;
      cmd_pulse_q <= wr_reg && hit(task_sel, idx, task_file_pkg::REG_STATUS);
      ctl_pulse_q <= wr_reg && hit(alt_sel, idx, task_file_pkg::ALT_STATUS);
      if (wr_reg && hit(task_sel, idx, task_file_pkg::REG_ERROR))
        feature_q <= wdat[7:0];
      if (count_load_i)
        count_q <= count_remaining_i;
      else if (wr_reg && hit(task_sel, idx, task_file_pkg::REG_COUNT))
        count_q <= wdat[7:0];
      if (wr_reg && hit(task_sel, idx, task_file_pkg::REG_SECTOR))
        sector_q <= wdat[7:0];
      if (wr_reg && hit(task_sel, idx, task_file_pkg::REG_CYL_LOW))
        cyl_lo_q <= wdat[7:0];
      if (wr_reg && hit(task_sel, idx, task_file_pkg::REG_CYL_HIGH))
        cyl_hi_q <= wdat[7:0];
      if (wr_reg && hit(task_sel, idx, task_file_pkg::REG_UNIT_HEAD))
        unit_head_q <= (wdat[7:0] & task_file_pkg::UNIT_HEAD_WMASK)
                       | task_file_pkg::UNIT_HEAD_FIXED;
      if (wr_reg && hit(task_sel, idx, task_file_pkg::REG_STATUS))
        command_q <= wdat[7:0];
      if (wr_reg && hit(alt_sel, idx, task_file_pkg::ALT_STATUS))
        control_q <= wdat[7:0];
      // writes to the reserved drive address slot fall through untouched
    end
  end

  // data port buffering: host writes enter a fifo, reads drain another
  wire wr_fifo_ready;
  wire wr_push = wr_start && is_data;
  data_fifo #(.WIDTH(16), .DEPTH(DATA_DEPTH)) wr_fifo (
    .clock_i     (clock_i),
    .reset_i     (reset_i),
    .in_valid_i  (wr_push),
    .in_ready_o  (wr_fifo_ready),
    .in_data_i   (wdat),
    .out_valid_o (wr_data_valid_o),
    .out_ready_i (wr_data_ready_i),
    .out_data_o  (wr_data_o)
  );
  wire        rd_fifo_valid;
  wire [15:0] rd_fifo_data;
  wire        rd_pop = rd_start && is_data && rd_fifo_valid;
  data_fifo #(.WIDTH(16), .DEPTH(DATA_DEPTH)) rd_fifo (
    .clock_i     (clock_i),
    .reset_i     (reset_i),
    .in_valid_i  (rd_data_valid_i),
    .in_ready_o  (rd_data_ready_o),
    .in_data_i   (rd_data_i),
    .out_valid_o (rd_fifo_valid),
    .out_ready_i (rd_pop),
    .out_data_o  (rd_fifo_data)
  );

  // read mux, captured at the start of the read strobe
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (alt_sel && idx == task_file_pkg::ALT_STATUS) rd_byte = status_i;
    else if (alt_sel) rd_byte = {2'h0, ~unit_head_q[3:0], ~unit_head_q[4], 1'b1};
    else unique case (idx)
      task_file_pkg::REG_DATA:      rd_byte = rd_fifo_data[7:0];
      task_file_pkg::REG_ERROR:     rd_byte = error_q;
      task_file_pkg::REG_COUNT:     rd_byte = count_q;
      task_file_pkg::REG_SECTOR:    rd_byte = sector_q;
      task_file_pkg::REG_CYL_LOW:   rd_byte = cyl_lo_q;
      task_file_pkg::REG_CYL_HIGH:  rd_byte = cyl_hi_q;
      task_file_pkg::REG_UNIT_HEAD: rd_byte = unit_head_q;
      task_file_pkg::REG_STATUS:    rd_byte = status_i;
    endcase
  end
  logic [15:0] dout_q;
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) dout_q <= 16'h0000;
    else if (rd_start) dout_q <= {is_data ? rd_fifo_data[15:8] : 8'h00, rd_byte};
  end
  assign host_data_o       = dout_q;
  assign host_data_lo_oe_o = rd_act && rd_prev_q;
  assign host_data_hi_oe_o = rd_act && rd_prev_q && is_data;

  // back-end view
  assign command_valid_o   = cmd_pulse_q;
  assign command_code_o    = command_q;
  assign control_valid_o   = ctl_pulse_q;
  assign control_byte_o    = control_q;
  assign feature_byte_o    = feature_q;
  assign sectors_to_move_o = (count_q == 8'h00) ? task_file_pkg::COUNT_ZERO_MEANS
                           : {1'b0, count_q};
  assign block_mode_o      = unit_head_q[task_file_pkg::BIT_MODE];
  assign unit_select_bit_o = unit_head_q[task_file_pkg::BIT_UNIT];
  assign block_address_o   = {unit_head_q[3:0], cyl_hi_q, cyl_lo_q, sector_q};
  assign head_number_o     = unit_head_q[3:0];
  assign cylinder_o        = {cyl_hi_q, cyl_lo_q};
  assign start_sector_o    = sector_q;
  wire unused = wr_fifo_ready ^ is_data_hi ^ (NSYNC == 0);
endmodule // ata_task_file_decode

// >>> dv/task_file_checker.sv
`timescale 1ns/1ps
module task_file_checker #(parameter int DATA_DEPTH = 8) (
  // clock and reset
  input wire logic        clock_i,
  input wire logic        reset_i,
  // host strobes
  input wire logic        io_read_n_i,
  input wire logic        io_write_n_i,
  // observed outputs and the write-side ready input
  input wire logic        host_data_lo_oe_o,
  input wire logic        host_data_hi_oe_o,
  input wire logic        command_valid_o,
  input wire logic        control_valid_o,
  input wire logic [7:0]  feature_byte_o,
  input wire logic [8:0]  sectors_to_move_o,
  input wire logic        wr_data_valid_o,
  input wire logic        wr_data_ready_i,
  input wire logic [15:0] wr_data_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  reset_vals_a: assert property ($fell(reset_i) |-> sectors_to_move_o == 9'h001)
    else $error("count not one after reset");
  count_range_a: assert property (
    sectors_to_move_o != 9'h000 && sectors_to_move_o <= 9'h100)
    else $error("sector count out of range");
  lane_pair_a: assert property (host_data_hi_oe_o |-> host_data_lo_oe_o)
    else $error("upper lane driven alone");
  drive_read_a: assert property (host_data_lo_oe_o |-> !io_read_n_i
    || !$past(io_read_n_i) || !$past(io_read_n_i, 2) || !$past(io_read_n_i, 4)
    || !$past(io_read_n_i, 5))
    else $error("bus driven without read");
  command_pulse_a: assert property (command_valid_o
    |-> !$past(io_write_n_i, 2) ##1 !command_valid_o)
    else $error("command pulse wrong");
  control_pulse_a: assert property (control_valid_o
    |-> !$past(io_write_n_i, 2) ##1 !control_valid_o)
    else $error("control pulse wrong");
  feature_write_a: assert property (!$stable(feature_byte_o) |-> !$past(io_write_n_i, 2))
    else $error("feature changed without write");
  fifo_hold_a: assert property (wr_data_valid_o && !wr_data_ready_i
    |=> wr_data_valid_o && $stable(wr_data_o))
    else $error("stalled word not held");
endmodule // task_file_checker
bind ata_task_file_decode task_file_checker #(.DATA_DEPTH(DATA_DEPTH)) task_file_checker_inst (
  .clock_i(clock_i), .reset_i(reset_i), .io_read_n_i(io_read_n_i), .io_write_n_i(io_write_n_i),
  .host_data_lo_oe_o(host_data_lo_oe_o), .host_data_hi_oe_o(host_data_hi_oe_o),
  .command_valid_o(command_valid_o), .control_valid_o(control_valid_o),
  .feature_byte_o(feature_byte_o), .sectors_to_move_o(sectors_to_move_o),
  .wr_data_valid_o(wr_data_valid_o), .wr_data_ready_i(wr_data_ready_i), .wr_data_o(wr_data_o));

// >>> dv/host_io_model.sv
`timescale 1ns/1ps
module host_io_model (
  // clock and read return
  input  wire logic        clock_i,
  input  wire logic [15:0] host_data_i,
  input  wire logic [1:0]  oe_i,
  // host pins, selects and strobes idle high
  output logic             reg_sel_n_o,
  output logic             cs1_n_o,
  output logic             cs2_n_o,
  output logic             rd_n_o,
  output logic             wr_n_o,
  output logic      [10:0] addr_o,
  output logic      [15:0] data_o
);
  initial {reg_sel_n_o, cs2_n_o, cs1_n_o, rd_n_o, wr_n_o, addr_o, data_o} = {5'h1F, 27'h5A5A};
  // strobes stay 6 clocks low and over 4 high so the pin filter always settles
  task automatic access(input logic wr, input logic [1:0] csn, input logic [10:0] a,
                        input logic [15:0] wd, output logic [15:0] rd, output logic [1:0] oe);
    @(posedge clock_i);
    #1;
    addr_o = a;
    {cs2_n_o, cs1_n_o, reg_sel_n_o} = {csn, 1'b0};
    data_o = wr ? wd : ~data_o;
    @(posedge clock_i);
    #1;
    {rd_n_o, wr_n_o} = wr ? 2'b10 : 2'b01;
    repeat (6) @(posedge clock_i);
    #1;
    rd = host_data_i;
    oe = oe_i;
    {rd_n_o, wr_n_o} = 2'b11;
    repeat (4) @(posedge clock_i);
    #1;
    {cs2_n_o, cs1_n_o, reg_sel_n_o} = 3'h7;
    // released bus shows the inverse, never a stale copy
    data_o = ~data_o;
  endtask
endmodule // host_io_model

// >>> dv/tb_ata_task_file_decode.sv
`timescale 1ns/1ps
module tb_ata_task_file_decode;
  localparam logic [5:0] PT = task_file_pkg::PRI_TASK_BASE;
  localparam logic [5:0] PA = task_file_pkg::PRI_ALT_BASE;
  logic        clock_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        ide = 1'b0;
  logic [1:0]  opt = task_file_pkg::OPT_PRIMARY;
  logic        rs_n, cs1_n, cs2_n, rd_n, wr_n, lo_oe, hi_oe, cmd_v, ctl_v;
  logic        blk, unit, wr_v, rd_rdy;
  logic        wr_rdy = 1'b0, rd_v = 1'b0, ld = 1'b0, clr = 1'b0;
  logic [4:0]  set_v = 5'h00;
  logic [7:0]  status = 8'h00, rem = 8'h00, cmd, ctl, feat, sec;
  logic [10:0] addr;
  logic [15:0] hdi, hdo, wr_dat, cyl;
  logic [15:0] rd_dat = 16'hBEEF;
  logic [8:0]  sectors;
  logic [27:0] lba;
  logic [3:0]  head;
  int          fails = 0, checks = 0, cmd_n = 0;
  logic [15:0] popped[$];
  initial forever #50 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    if (cmd_v === 1'b1) cmd_n++;
    if (wr_v === 1'b1 && wr_rdy) popped.push_back(wr_dat);
  end
  ata_task_file_decode #(.DATA_DEPTH(8)) ata_task_file_decode_inst (
    .clock_i(clock_i), .reset_i(reset_i), .ide_mode_i(ide), .config_option_i(opt),
    .reg_select_n_i(rs_n), .chip_sel1_n_i(cs1_n), .chip_sel2_n_i(cs2_n), .addr_i(addr),
    .io_read_n_i(rd_n), .io_write_n_i(wr_n), .host_data_i(hdi), .host_data_o(hdo),
    .host_data_lo_oe_o(lo_oe), .host_data_hi_oe_o(hi_oe), .status_i(status),
    .set_bad_block_i(set_v[4]), .set_uncorrectable_i(set_v[3]), .set_id_missing_i(set_v[2]),
    .set_aborted_i(set_v[1]), .set_general_i(set_v[0]), .clear_errors_i(clr),
    .count_load_i(ld), .count_remaining_i(rem), .command_valid_o(cmd_v), .command_code_o(cmd),
    .control_valid_o(ctl_v), .control_byte_o(ctl), .feature_byte_o(feat),
    .sectors_to_move_o(sectors), .block_mode_o(blk), .unit_select_bit_o(unit),
    .block_address_o(lba), .head_number_o(head), .cylinder_o(cyl), .start_sector_o(sec),
    .wr_data_valid_o(wr_v), .wr_data_ready_i(wr_rdy), .wr_data_o(wr_dat),
    .rd_data_valid_i(rd_v), .rd_data_ready_o(rd_rdy), .rd_data_i(rd_dat));
  host_io_model host_io_model_inst (
    .clock_i(clock_i), .host_data_i(hdo), .oe_i({hi_oe, lo_oe}), .reg_sel_n_o(rs_n),
    .cs1_n_o(cs1_n), .cs2_n_o(cs2_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .addr_o(addr), .data_o(hdi));
  task automatic check(input logic [27:0] seen, input logic [27:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic [10:0] at(input logic [5:0] base, input logic [2:0] idx);
    return {1'b0, base, 1'b0, idx};
  endfunction
  task automatic wr(input logic [1:0] csn, input logic [10:0] a, input logic [15:0] d);
    logic [15:0] r;
    logic [1:0]  o;
    host_io_model_inst.access(1'b1, csn, a, d, r, o);
  endtask
  // chip selects both low means a word access, otherwise the low byte lane alone
  task automatic rd(input logic [1:0] csn, input logic [10:0] a, input logic [15:0] exp);
    logic [15:0] r;
    logic [1:0]  o;
    host_io_model_inst.access(1'b0, csn, a, 16'h0000, r, o);
    if (csn == 2'b00) check(28'({o, r}), 28'({2'b11, exp}));
    else check(28'({o, r[7:0]}), 28'({2'b01, exp[7:0]}));
  endtask
  task automatic t_regs();
    rd(2'b10, at(PT, 3'h2), 16'h0001);
    rd(2'b10, at(PT, 3'h6), 16'h00A0);
    wr(2'b10, at(PT, 3'h3), 16'h0033);
    wr(2'b10, at(PT, 3'h4), 16'h0044);
    wr(2'b10, at(PT, 3'h5), 16'h0055);
    wr(2'b10, at(PT, 3'h6), 16'h004B);
    rd(2'b10, at(PT, 3'h3), 16'h0033);
    rd(2'b10, at(PT, 3'h5), 16'h0055);
    rd(2'b10, at(PT, 3'h6), 16'h00EB);
    check(28'({sec, cyl}), 28'h0335544);
    check(lba, 28'hB554433);
    wr(2'b10, at(PT, 3'h6), 16'h0013);
    check(28'({blk, unit, head}), 28'h13);
    wr(2'b10, at(PT, 3'h2), 16'h0000);
    check(28'(sectors), 28'h100);
    wr(2'b10, at(PT, 3'h1), 16'h0077);
    check(28'(feat), 28'h77);
    rd(2'b10, at(PT, 3'h1), 16'h0000);
  endtask
  task automatic t_maps();
    logic [15:0] r;
    logic [1:0]  o;
    status = 8'h50;
    rd(2'b10, at(PT, 3'h7), 16'h0050);
    rd(2'b10, at(PA, 3'h6), 16'h0050);
    wr(2'b10, at(PT, 3'h7), 16'h00C4);
    check(28'({cmd_n[3:0], cmd}), 28'h1C4);
    wr(2'b10, at(PA, 3'h6), 16'h0006);
    wr(2'b10, at(PA, 3'h7), 16'h0099);
    rd(2'b10, at(PA, 3'h7), 16'h0031);
    wr(2'b10, at(6'h1E, 3'h3), 16'h00EE);
    check(28'({cmd_n[3:0], ctl}), 28'h106);
    host_io_model_inst.access(1'b0, 2'b10, at(6'h1E, 3'h3), 16'h0000, r, o);
    check(28'(o), 28'h0);
    opt = task_file_pkg::OPT_SECONDARY;
    wr(2'b10, at(PT, 3'h3), 16'h0011);
    wr(2'b10, at(task_file_pkg::SEC_TASK_BASE, 3'h4), 16'h0066);
    rd(2'b10, at(task_file_pkg::SEC_TASK_BASE, 3'h3), 16'h0033);
    rd(2'b10, at(task_file_pkg::SEC_ALT_BASE, 3'h6), 16'h0050);
    ide = 1'b1;
    rd(2'b10, 11'h004, 16'h0066);
    rd(2'b01, 11'h006, 16'h0050);
    ide = 1'b0;
    opt = task_file_pkg::OPT_PRIMARY;
  endtask
  task automatic t_errors();
    logic [4:0] b;
    logic [7:0] e;
    status = 8'h00; // busy clear before the error byte is trusted
    for (int i = 0; i < 6; i++) begin
      b = (i == 5) ? 5'h1F : 5'(1 << i);
      e = {b[4:3], 1'b0, b[2], 1'b0, b[1], 1'b0, b[0]};
      set_v = b;
      @(posedge clock_i);
      #1 set_v = 5'h00;
      rd(2'b10, at(PT, 3'h1), {8'h00, e});
      clr = 1'b1;
      @(posedge clock_i);
      #1 clr = 1'b0;
    end
    rem = 8'h05;
    ld = 1'b1;
    @(posedge clock_i);
    #1 ld = 1'b0;
    rd(2'b10, at(PT, 3'h2), 16'h0005);
  endtask
  task automatic t_data();
    for (int i = 0; i < 9; i++) wr(2'b00, at(PT, 3'h0), 16'hA000 + 16'(i));
    check(28'(wr_v), 28'h1);
    wr_rdy = 1'b1;
    repeat (12) @(posedge clock_i);
    #1 wr_rdy = 1'b0;
    check(28'(popped.size()), 28'h0000008);
    check(28'({popped[0], popped[7][11:0]}), 28'hA000007);
    rd_v = 1'b1;
    do @(posedge clock_i); while (rd_rdy !== 1'b1);
    #1 rd_v = 1'b0;
    rd(2'b00, at(PT, 3'h0), 16'hBEEF);
  endtask
  initial begin
    #3000000;
    fails++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge clock_i);
    #1 reset_i = 1'b0;
    t_regs();
    t_maps();
    t_errors();
    t_data();
    conclude();
  end
endmodule // tb_ata_task_file_decode
